/* core/rip_params.svh */
`ifndef RIP_PARAMS_SVH
`define RIP_PARAMS_SVH

// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define RIP_CLK_PERIOD_NS 25
`define RIP_WAIT_RESET 3'h7
`define RIP_WAIT_NONE 3'h0
`define RIP_WAIT_W 3
`define RIP_VECTOR_FETCHES 2'h2
`define RIP_RESET_MIN_H1 4'ha
`define RIP_IRQ_COUNT 4
`define RIP_STROBE_COUNT 3

`endif

/* core/rip_pkg.sv */
package rip_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    RIP_HELD = 2'h0,
    RIP_FETCH = 2'h1,
    RIP_WAIT = 2'h3,
    RIP_RUN = 2'h2
  } rip_state_t;

  // Filtered level: moves only when stages two and three agree
  function automatic logic rip_settle(input logic s2, input logic s3, input logic prev);
    rip_settle = (s2 == s3) ? s3 : prev;
  endfunction : rip_settle

endpackage : rip_pkg

/* core/rip_phase_if.sv */
`timescale 1ns/1ps
interface rip_phase_if;
  logic h1_fall;
  logic dev_reset;
  logic fetch_boundary;
  logic [3:0] take;
  logic [3:0] pending;

  modport src (
    output h1_fall,
    output dev_reset,
    output fetch_boundary,
    input take,
    input pending
  );
  modport snk (
    input h1_fall,
    input dev_reset,
    input fetch_boundary,
    output take,
    output pending
  );
endinterface : rip_phase_if

/* core/rip_irq_sampler.sv */
`timescale 1ns/1ps
`include "rip_params.svh"
module rip_irq_sampler
  import rip_pkg::*;
#(
  parameter int IRQ_COUNT = `RIP_IRQ_COUNT
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [IRQ_COUNT-1:0] ext_irq_inputs_n_in,
  rip_phase_if.snk ph
);

  initial begin
    if (IRQ_COUNT != `RIP_IRQ_COUNT)
    begin
      $error("rip_irq_sampler: IRQ_COUNT must match the interface width");
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_COUNT; gi = gi + 1)
    begin : g_irq
      logic s1_q, s2_q, s3_q, lvl_n_q;
      logic pend_q, block_q, take_q;

      // ----------------------------------------
      // Pin synchroniser
      // ----------------------------------------
      always_ff @(posedge clock_in)
      begin
        if (rst_in)
        begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_n_q <= 1'b1;
        end
        else
        begin
          s1_q <= ext_irq_inputs_n_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_n_q <= rip_settle(s2_q, s3_q, lvl_n_q);
        end
      end

      // ----------------------------------------
      // Level sampled at phase1 falling edge
      // ----------------------------------------
      // Skipping the edge after a hit keeps a two-edge pulse to one request
      always_ff @(posedge clock_in)
      begin
        if (rst_in || ph.dev_reset)
        begin
          block_q <= 1'b0;
        end
        else if (ph.h1_fall)
        begin
          block_q <= !lvl_n_q && !block_q;
        end
      end

      always_ff @(posedge clock_in)
      begin
        if (rst_in || ph.dev_reset)
        begin
          pend_q <= 1'b0;
        end
        else if (ph.h1_fall && !lvl_n_q && !block_q)
        begin
          pend_q <= 1'b1;
        end
        else if (take_q)
        begin
          pend_q <= 1'b0;
        end
      end

      // Taken only at a fetch boundary; a fresh set beats the clear above
      always_ff @(posedge clock_in)
      begin
        if (rst_in || ph.dev_reset)
        begin
          take_q <= 1'b0;
        end
        else
        begin
          take_q <= pend_q && !take_q && ph.fetch_boundary;
        end
      end

      assign ph.take[gi] = take_q;
      assign ph.pending[gi] = pend_q;
    end
  endgenerate

endmodule : rip_irq_sampler

/* core/rip_reset_pin_unit.sv */
`timescale 1ns/1ps
`include "rip_params.svh"
// How it works
// - Reset pin synchronised; one extra cycle possible
// - Reset loads seven wait states on both buses
// - Data released at phase1, address at phase3
// - Strobes forced high from phase3 rising
// - Both read/write lines released during reset
// - Acknowledge strobe forced high at phase1 rising
// - Flag, serial, timer pins float without clock
// - Vector fetched twice; wait states by mode
// - Hold request synchronised, tolerated during reset
// - Interrupt inputs are level, active low, async
// - Interrupts sampled at phase1 falling edge
// - Interrupts taken only at fetch boundaries
// - Same input accepted every two phase1 cycles
// - Acknowledge low from decode to read phase
// - Acknowledge low exactly one phase1 cycle despite stalls
module rip_reset_pin_unit
  import rip_pkg::*;
#(
  parameter int IRQ_COUNT = `RIP_IRQ_COUNT,
  parameter int WAIT_W = `RIP_WAIT_W
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic hold_req_n_in,
  input wire logic mcu_mode_in,
  input wire logic [IRQ_COUNT-1:0] ext_irq_inputs_n_in,
  input wire logic fetch_boundary_in,
  input wire logic irq_ack_strobe_decode_in,
  input wire logic wait_wr_in,
  input wire logic [WAIT_W-1:0] primary_wait_in,
  input wire logic [WAIT_W-1:0] expansion_wait_in,
  input wire logic vector_ack_in,
  input wire logic core_data_oe_in,
  input wire logic core_addr_oe_in,
  input wire logic core_rw_oe_in,
  input wire logic [`RIP_STROBE_COUNT-1:0] core_strobe_n_in,
  input wire logic [1:0] flag_pins_oe_in,
  input wire logic [11:0] serial_pins_oe_in,
  input wire logic [1:0] timer_clock_pins_oe_in,
  output logic phase1_clock_out,
  output logic phase3_clock_out,
  output logic device_reset_out,
  output logic core_run_out,
  output logic hold_req_out,
  output logic [WAIT_W-1:0] primary_wait_out,
  output logic [WAIT_W-1:0] expansion_wait_out,
  output logic vector_fetch_out,
  output logic [WAIT_W-1:0] vector_wait_out,
  output logic primary_data_oe_out,
  output logic expansion_data_oe_out,
  output logic primary_addr_oe_out,
  output logic expansion_addr_oe_out,
  output logic primary_read_write_oe_out,
  output logic expansion_read_write_oe_out,
  output logic primary_strobe_n_out,
  output logic mem_strobe_n_out,
  output logic io_strobe_n_out,
  output logic irq_ack_strobe_n_out,
  output logic [IRQ_COUNT-1:0] irq_take_out,
  output logic [IRQ_COUNT-1:0] irq_pending_out,
  output logic [1:0] flag_pins_oe_out,
  output logic [11:0] serial_pins_oe_out,
  output logic [1:0] timer_clock_pins_oe_out
);

  initial begin
    if (IRQ_COUNT != `RIP_IRQ_COUNT || WAIT_W < `RIP_WAIT_W)
    begin
      $error("rip_reset_pin_unit: unsupported IRQ_COUNT or WAIT_W");
    end
  end

  // ----------------------------------------
  // Phase clocks
  // ----------------------------------------
  logic ph_q;
  logic h1_rise;
  logic h1_fall;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ph_q <= 1'b0;
    end
    else
    begin
      ph_q <= !ph_q;
    end
  end

  // Strobes mark the edge at which phase1 changes
  assign h1_rise = !ph_q;
  assign h1_fall = ph_q;
  assign phase1_clock_out = ph_q;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      phase3_clock_out <= 1'b1;
    end
    else
    begin
      phase3_clock_out <= ph_q;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic rs1_q, rs2_q, rs3_q, rpin_q;
  logic hs1_q, hs2_q, hs3_q, hpin_q;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
      rs3_q <= 1'b0;
      rpin_q <= 1'b0;
    end
    else
    begin
      rs1_q <= reset_pin_n_in;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
      rpin_q <= rip_settle(rs2_q, rs3_q, rpin_q);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      hs1_q <= 1'b1;
      hs2_q <= 1'b1;
      hs3_q <= 1'b1;
      hpin_q <= 1'b1;
    end
    else
    begin
      hs1_q <= hold_req_n_in;
      hs2_q <= hs1_q;
      hs3_q <= hs2_q;
      hpin_q <= rip_settle(hs2_q, hs3_q, hpin_q);
    end
  end

  // Passed on unchanged even while reset is active
  assign hold_req_out = !hpin_q;

  // ----------------------------------------
  // Device reset
  // ----------------------------------------
  logic dev_rst_q;

  // Release only at a phase1 falling edge; the driver keeps the ten-cycle minimum
  always_ff @(posedge clock_in)
  begin
    if (rst_in || !rpin_q)
    begin
      dev_rst_q <= 1'b1;
    end
    else if (h1_fall)
    begin
      dev_rst_q <= 1'b0;
    end
  end

  assign device_reset_out = dev_rst_q;

  // ----------------------------------------
  // Wait-state registers
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in || dev_rst_q)
    begin
      primary_wait_out <= WAIT_W'(`RIP_WAIT_RESET);
      expansion_wait_out <= WAIT_W'(`RIP_WAIT_RESET);
    end
    else if (wait_wr_in)
    begin
      primary_wait_out <= primary_wait_in;
      expansion_wait_out <= expansion_wait_in;
    end
  end

  // ----------------------------------------
  // Reset vector fetch
  // ----------------------------------------
  rip_state_t state_q;
  logic [1:0] fetch_cnt_q;

  always_ff @(posedge clock_in)
  begin
    if (rst_in || dev_rst_q)
    begin
      state_q <= RIP_HELD;
      fetch_cnt_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        RIP_HELD:
        begin
          state_q <= RIP_FETCH;
        end
        RIP_FETCH:
        begin
          state_q <= RIP_WAIT;
          fetch_cnt_q <= fetch_cnt_q + 2'h1;
        end
        RIP_WAIT:
        begin
          if (vector_ack_in)
          begin
            state_q <= (fetch_cnt_q == `RIP_VECTOR_FETCHES) ? RIP_RUN : RIP_FETCH;
          end
        end
        RIP_RUN:
        begin
          state_q <= RIP_RUN;
        end
        default:
        begin
          state_q <= RIP_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      vector_fetch_out <= 1'b0;
      vector_wait_out <= WAIT_W'(`RIP_WAIT_RESET);
    end
    else
    begin
      vector_fetch_out <= (state_q == RIP_FETCH) && !dev_rst_q;
      vector_wait_out <= mcu_mode_in ? WAIT_W'(`RIP_WAIT_NONE) : WAIT_W'(`RIP_WAIT_RESET);
    end
  end

  assign core_run_out = (state_q == RIP_RUN);

  // ----------------------------------------
  // Bus pins at phase1 rising
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      primary_data_oe_out <= 1'b0;
      expansion_data_oe_out <= 1'b0;
      primary_read_write_oe_out <= 1'b0;
      expansion_read_write_oe_out <= 1'b0;
    end
    else if (h1_rise)
    begin
      primary_data_oe_out <= core_data_oe_in && !dev_rst_q;
      expansion_data_oe_out <= core_data_oe_in && !dev_rst_q;
      primary_read_write_oe_out <= core_rw_oe_in && !dev_rst_q;
      expansion_read_write_oe_out <= core_rw_oe_in && !dev_rst_q;
    end
  end

  // ----------------------------------------
  // Bus pins at phase3 rising
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      primary_addr_oe_out <= 1'b0;
      expansion_addr_oe_out <= 1'b0;
      primary_strobe_n_out <= 1'b1;
      mem_strobe_n_out <= 1'b1;
      io_strobe_n_out <= 1'b1;
    end
    else if (h1_fall)
    begin
      primary_addr_oe_out <= core_addr_oe_in && !dev_rst_q;
      expansion_addr_oe_out <= core_addr_oe_in && !dev_rst_q;
      primary_strobe_n_out <= core_strobe_n_in[0] || dev_rst_q;
      mem_strobe_n_out <= core_strobe_n_in[1] || dev_rst_q;
      io_strobe_n_out <= core_strobe_n_in[2] || dev_rst_q;
    end
  end

  // ----------------------------------------
  // Pins floated straight from the reset pin
  // ----------------------------------------
  // No clock in this path, so the pins float even with the oscillator stopped
  assign flag_pins_oe_out = flag_pins_oe_in & {2{reset_pin_n_in}};
  assign serial_pins_oe_out = serial_pins_oe_in & {12{reset_pin_n_in}};
  assign timer_clock_pins_oe_out = timer_clock_pins_oe_in & {2{reset_pin_n_in}};

  // ----------------------------------------
  // Interrupt acknowledge strobe
  // ----------------------------------------
  logic irq_ack_strobe_seen_q;

  // Seen flag stops a stretched decode from opening a second low cycle
  always_ff @(posedge clock_in)
  begin
    if (rst_in || dev_rst_q)
    begin
      irq_ack_strobe_seen_q <= 1'b0;
    end
    else if (h1_rise)
    begin
      irq_ack_strobe_seen_q <= irq_ack_strobe_decode_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      irq_ack_strobe_n_out <= 1'b1;
    end
    else if (h1_rise)
    begin
      irq_ack_strobe_n_out <= dev_rst_q || !irq_ack_strobe_decode_in || irq_ack_strobe_seen_q;
    end
  end

  // ----------------------------------------
  // External interrupts
  // ----------------------------------------
  rip_phase_if ph ();

  assign ph.h1_fall = h1_fall;
  assign ph.dev_reset = dev_rst_q;
  assign ph.fetch_boundary = fetch_boundary_in;
  assign irq_take_out = ph.take;
  assign irq_pending_out = ph.pending;

  // Recognition counts on sources keeping pulses to two falling edges
  rip_irq_sampler #(
    .IRQ_COUNT(IRQ_COUNT)
  ) u_irq (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ext_irq_inputs_n_in(ext_irq_inputs_n_in),
    .ph(ph)
  );

endmodule : rip_reset_pin_unit

/* verification/rip_reset_pin_unit_monitor.sv */
`timescale 1ns/1ps
module rip_reset_pin_unit_monitor
  import rip_pkg::*;
#(
  parameter int IRQ_COUNT = 4,
  parameter int WAIT_W = 3
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reset_pin_n_in,
  input wire logic hold_req_n_in,
  input wire logic mcu_mode_in,
  input wire logic fetch_boundary_in,
  input wire logic phase1_clock_out,
  input wire logic device_reset_out,
  input wire logic hold_req_out,
  input wire logic [WAIT_W-1:0] primary_wait_out,
  input wire logic [WAIT_W-1:0] expansion_wait_out,
  input wire logic vector_fetch_out,
  input wire logic [WAIT_W-1:0] vector_wait_out,
  input wire logic primary_data_oe_out,
  input wire logic expansion_data_oe_out,
  input wire logic primary_addr_oe_out,
  input wire logic expansion_addr_oe_out,
  input wire logic primary_read_write_oe_out,
  input wire logic expansion_read_write_oe_out,
  input wire logic primary_strobe_n_out,
  input wire logic mem_strobe_n_out,
  input wire logic io_strobe_n_out,
  input wire logic irq_ack_strobe_n_out,
  input wire logic [IRQ_COUNT-1:0] irq_take_out,
  input wire logic [1:0] flag_pins_oe_out,
  input wire logic [11:0] serial_pins_oe_out,
  input wire logic [1:0] timer_clock_pins_oe_out
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  waits_loaded_a: assert property (device_reset_out [*3] |->
    primary_wait_out == 3'h7 && expansion_wait_out == 3'h7) else $error("wait states not seven in reset");
  bus_release_a: assert property (device_reset_out [*3] |->
    !primary_data_oe_out && !expansion_data_oe_out && !primary_addr_oe_out && !expansion_addr_oe_out)
    else $error("bus driven in reset");
  strobes_high_a: assert property (device_reset_out [*3] |->
    primary_strobe_n_out && mem_strobe_n_out && io_strobe_n_out) else $error("strobe low in reset");
  rw_release_a: assert property (device_reset_out [*3] |->
    !primary_read_write_oe_out && !expansion_read_write_oe_out) else $error("rw driven in reset");
  ack_high_a: assert property (device_reset_out [*3] |-> irq_ack_strobe_n_out)
    else $error("ack low in reset");
  async_float_a: assert property (!reset_pin_n_in |->
    {flag_pins_oe_out, serial_pins_oe_out, timer_clock_pins_oe_out} == 16'h0000) else $error("pins driven");
  ack_phase_a: assert property ($fell(irq_ack_strobe_n_out) |->
    phase1_clock_out && !$past(phase1_clock_out)) else $error("ack off phase1 rise");
  ack_width_a: assert property ($fell(irq_ack_strobe_n_out) |=>
    !irq_ack_strobe_n_out ##1 irq_ack_strobe_n_out) else $error("ack width wrong");
  take_boundary_a: assert property (|irq_take_out |-> $past(fetch_boundary_in))
    else $error("take off boundary");
  take_spacing_a: assert property (irq_take_out[0] |=> !irq_take_out[0] [*3])
    else $error("takes too close");
  vector_wait_a: assert property (vector_fetch_out |->
    vector_wait_out == ($past(mcu_mode_in) ? 3'h0 : 3'h7)) else $error("vector wait wrong");
  hold_sync_a: assert property ($fell(hold_req_n_in) |-> ##[1:6] hold_req_out)
    else $error("hold not seen");
  cover property ($fell(irq_ack_strobe_n_out));
  cover property (|irq_take_out);
  cover property (vector_fetch_out && mcu_mode_in);
endmodule : rip_reset_pin_unit_monitor

bind rip_reset_pin_unit rip_reset_pin_unit_monitor #(.IRQ_COUNT(IRQ_COUNT), .WAIT_W(WAIT_W)) u_mon (
  .clock_in(clock_in), .rst_in(rst_in), .reset_pin_n_in(reset_pin_n_in), .hold_req_n_in(hold_req_n_in),
  .mcu_mode_in(mcu_mode_in), .fetch_boundary_in(fetch_boundary_in), .phase1_clock_out(phase1_clock_out),
  .device_reset_out(device_reset_out), .hold_req_out(hold_req_out), .primary_wait_out(primary_wait_out),
  .expansion_wait_out(expansion_wait_out), .vector_fetch_out(vector_fetch_out),
  .vector_wait_out(vector_wait_out), .primary_data_oe_out(primary_data_oe_out),
  .expansion_data_oe_out(expansion_data_oe_out), .primary_addr_oe_out(primary_addr_oe_out),
  .expansion_addr_oe_out(expansion_addr_oe_out), .primary_read_write_oe_out(primary_read_write_oe_out),
  .expansion_read_write_oe_out(expansion_read_write_oe_out), .primary_strobe_n_out(primary_strobe_n_out),
  .mem_strobe_n_out(mem_strobe_n_out), .io_strobe_n_out(io_strobe_n_out),
  .irq_ack_strobe_n_out(irq_ack_strobe_n_out), .irq_take_out(irq_take_out),
  .flag_pins_oe_out(flag_pins_oe_out), .serial_pins_oe_out(serial_pins_oe_out),
  .timer_clock_pins_oe_out(timer_clock_pins_oe_out));

/* verification/rip_far_side.sv */
`timescale 1ns/1ps
module rip_far_side (
  input wire logic clock_in,
  input wire logic reset_go_in,
  input wire logic [3:0] irq_go_in,
  input wire logic [3:0] irq_hold_in,
  output logic reset_pin_n_out,
  output logic [3:0] ext_irq_n_out
);
  // ----------------------------------------
  // Reset driver and interrupt sources
  // ----------------------------------------
  int unsigned rst_cnt = 0;
  int unsigned irq_cnt [4] = '{default: 0};
  // Lines move off the sampling edge only
  always @(negedge clock_in)
  begin
    if (reset_go_in)
      rst_cnt <= 24;
    else if (rst_cnt != 0)
      rst_cnt <= rst_cnt - 1;
    for (int i = 0; i < 4; i++)
      if (irq_go_in[i])
        irq_cnt[i] <= 2;
      else if (irq_cnt[i] != 0)
        irq_cnt[i] <= irq_cnt[i] - 1;
  end
  assign reset_pin_n_out = (rst_cnt == 0);
  always_comb
    for (int i = 0; i < 4; i++)
      ext_irq_n_out[i] = !(irq_cnt[i] != 0 || irq_hold_in[i]);
endmodule : rip_far_side

/* verification/reset_and_interrupt_pin_logic_tb.sv */
`timescale 1ns/1ps
`define RIP_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t value mismatch", $time); end end
module reset_and_interrupt_pin_logic_tb;
  logic clock_in = 0, rst_in = 1, hold_n = 1, mode = 0, fb = 0, irq_ack_strobe_dec = 0, wait_wr = 0, vec_ack = 0;
  logic core_oe = 0, reset_go = 0, reset_pin_n, ph1, ph3, dev_rst, run, hold_out, vfetch;
  logic pdo, xdo, pao, xao, prw, xrw, ps, ms, ios, ack;
  logic [2:0] strobe_n = 3'h7, pw = 3'h0, xw = 3'h0, pwo, xwo, vwait;
  logic [3:0] irq_go = 4'h0, irq_hold = 4'h0, irq_n, take, pend;
  logic [1:0] flo, tmo;
  logic [11:0] sro;
  int failures = 0;
  int checks_done = 0;

  always #12.5 clock_in = ~clock_in;

  rip_far_side u_far (.clock_in(clock_in), .reset_go_in(reset_go), .irq_go_in(irq_go),
    .irq_hold_in(irq_hold), .reset_pin_n_out(reset_pin_n), .ext_irq_n_out(irq_n));

  rip_reset_pin_unit u_dut (.clock_in(clock_in), .rst_in(rst_in), .reset_pin_n_in(reset_pin_n),
    .hold_req_n_in(hold_n), .mcu_mode_in(mode), .ext_irq_inputs_n_in(irq_n), .fetch_boundary_in(fb),
    .irq_ack_strobe_decode_in(irq_ack_strobe_dec), .wait_wr_in(wait_wr), .primary_wait_in(pw), .expansion_wait_in(xw),
    .vector_ack_in(vec_ack), .core_data_oe_in(core_oe), .core_addr_oe_in(core_oe), .core_rw_oe_in(core_oe),
    .core_strobe_n_in(strobe_n), .flag_pins_oe_in({2{core_oe}}), .serial_pins_oe_in({12{core_oe}}),
    .timer_clock_pins_oe_in({2{core_oe}}), .phase1_clock_out(ph1), .phase3_clock_out(ph3),
    .device_reset_out(dev_rst), .core_run_out(run), .hold_req_out(hold_out), .primary_wait_out(pwo),
    .expansion_wait_out(xwo), .vector_fetch_out(vfetch), .vector_wait_out(vwait),
    .primary_data_oe_out(pdo), .expansion_data_oe_out(xdo), .primary_addr_oe_out(pao),
    .expansion_addr_oe_out(xao), .primary_read_write_oe_out(prw), .expansion_read_write_oe_out(xrw),
    .primary_strobe_n_out(ps), .mem_strobe_n_out(ms), .io_strobe_n_out(ios), .irq_ack_strobe_n_out(ack),
    .irq_take_out(take), .irq_pending_out(pend), .flag_pins_oe_out(flo), .serial_pins_oe_out(sro),
    .timer_clock_pins_oe_out(tmo));

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick

  task automatic wrap_up;
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic t_sys_reset;
    `RIP_CHK({pwo, xwo}, 6'h3f)
    `RIP_CHK({pdo, pao, prw, xrw}, 4'h0)
    `RIP_CHK({ps, ms, ios, ack}, 4'hf)
  endtask : t_sys_reset

  task automatic t_pin_reset(input logic m);
    int n;
    @(negedge clock_in);
    mode <= m; core_oe <= 1; strobe_n <= 3'h0; wait_wr <= 1; pw <= 3'h2; xw <= 3'h5;
    @(negedge clock_in);
    wait_wr <= 0;
    tick(4);
    `RIP_CHK({pdo, xdo, pao, xao}, 4'hf)
    `RIP_CHK({prw, xrw}, 2'h3)
    `RIP_CHK({ps, ms, ios}, 3'h0)
    `RIP_CHK(ph3, !ph1)
    `RIP_CHK({pwo, xwo}, {3'h2, 3'h5})
    @(negedge clock_in);
    reset_go <= 1; hold_n <= 0;
    @(negedge clock_in);
    reset_go <= 0;
    #1;
    `RIP_CHK({flo, sro, tmo}, 16'h0000)
    n = 0;
    while (dev_rst !== 1'b1 && n < 12)
    begin
      tick(1);
      n++;
    end
    `RIP_CHK(dev_rst === 1'b1 && n <= 6, 1'b1)
    tick(3);
    `RIP_CHK({pdo, xdo, pao, xao}, 4'h0)
    `RIP_CHK({prw, xrw}, 2'h0)
    `RIP_CHK({ps, ms, ios}, 3'h7)
    `RIP_CHK(ack, 1'b1)
    `RIP_CHK({pwo, xwo}, 6'h3f)
    `RIP_CHK(hold_out, 1'b1)
    n = 0;
    while (dev_rst !== 1'b0 && n < 40)
    begin
      tick(1);
      n++;
    end
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      while (vfetch !== 1'b1 && n < 8)
      begin
        tick(1);
        n++;
      end
      `RIP_CHK(vfetch, 1'b1)
      `RIP_CHK(vwait, m ? 3'h0 : 3'h7)
      `RIP_CHK(run, 1'b0)
      @(negedge clock_in);
      vec_ack <= 1;
      @(negedge clock_in);
      vec_ack <= 0;
    end
    tick(2);
    `RIP_CHK(run, 1'b1)
    @(negedge clock_in);
    hold_n <= 1; core_oe <= 0; strobe_n <= 3'h7;
  endtask : t_pin_reset

  task automatic t_irq;
    int n = 0;
    @(negedge clock_in);
    irq_go[1] <= 1;
    @(negedge clock_in);
    irq_go[1] <= 0;
    tick(10);
    `RIP_CHK(pend[1], 1'b1)
    `RIP_CHK(take, 4'h0)
    @(negedge clock_in);
    fb <= 1;
    repeat (12)
    begin
      tick(1);
      if (take[1] === 1'b1)
        n++;
    end
    `RIP_CHK(n, 1)
    `RIP_CHK(pend, 4'h0)
  endtask : t_irq

  task automatic t_irq_level;
    int n = 0;
    @(negedge clock_in);
    irq_hold[0] <= 1;
    repeat (28)
    begin
      tick(1);
      if (take[0] === 1'b1)
        n++;
    end
    @(negedge clock_in);
    irq_hold[0] <= 0;
    tick(8);
    `RIP_CHK(n >= 5 && n <= 7, 1'b1)
  endtask : t_irq_level

  task automatic t_irq_ack_strobe;
    int n = 0;
    @(negedge clock_in);
    irq_ack_strobe_dec <= 1;
    repeat (10)
    begin
      tick(1);
      if (ack === 1'b0)
        n++;
    end
    @(negedge clock_in);
    irq_ack_strobe_dec <= 0;
    tick(4);
    `RIP_CHK(n, 2)
  endtask : t_irq_ack_strobe

  initial
  begin
    int wd;
    wd = 0;
    tick(3);
    t_sys_reset();
    @(negedge clock_in);
    rst_in <= 0;
    tick(2);
    // Internal reset outlives the system reset until the pin sync settles
    while (dev_rst !== 1'b0 && wd < 20)
    begin
      tick(1);
      wd++;
    end
    `RIP_CHK(dev_rst, 1'b0)
    t_pin_reset(1'b0);
    t_pin_reset(1'b1);
    t_irq();
    t_irq_level();
    t_irq_ack_strobe();
    wrap_up();
  end

  // Whole run is a few hundred cycles; this is ample
  initial
  begin
    #150000;
    failures++;
    wrap_up();
  end
endmodule : reset_and_interrupt_pin_logic_tb
